/* hw/scs_clock_switch.sv */
// System clock generation and switching with register port and crystal failover
`timescale 1ns/1ps
`default_nettype none
`include "scs_cfg.svh"

module scs_clock_switch (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        fast_rc_osc_i,
  input  wire logic        fast_crystal_osc_i,
  input  wire logic        slow_rc_osc_10k_i,
  input  wire logic        slow_crystal_osc_i,
  input  wire logic        flash_busy_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             main_clock_o,
  output logic             periph_clock_o,
  output logic             processor_clock_o,
  output logic             ram_clock_o,
  output logic             ref_clock_1k_o,
  output logic             slow_crystal_clock_o,
  output logic             crystal_enable_o,
  output logic [3:0]       crystal_bias_o,
  output logic [4:0]       fast_rc_tune_o,
  output logic [3:0]       slow_rc_tune_o,
  output logic             main_is_crystal_o,
  output logic             radio_clock_ok_o,
  output logic             nmi_o,
  output logic             irq_o
);

  localparam logic [8:0] FAIL_CYC = 9'(`SCS_XTAL_FAIL_CYC);

  scs_pkg::scs_bus_req_t req;
  scs_pkg::scs_cfg_t     cfg;
  logic [2:0]            irq_status;
  logic [2:0]            irq_mask;

  // Bundle the bus request
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Address decode
  wire hit_slow_tune = req.addr == `SCS_OFS_SLOW_TUNE;
  wire hit_ref_div   = req.addr == `SCS_OFS_REF_DIV;
  wire hit_bias      = req.addr == `SCS_OFS_BIAS;
  wire hit_fast_tune = req.addr == `SCS_OFS_FAST_TUNE;
  wire hit_xtal_ctrl = req.addr == `SCS_OFS_CRYSTAL_CTRL;
  wire hit_cpu_clock = req.addr == `SCS_OFS_CPU_CLOCK;
  wire hit_irq_stat  = req.addr == `SCS_OFS_IRQ_STATUS;
  wire hit_irq_mask  = req.addr == `SCS_OFS_IRQ_MASK;
  wire hit_clk_stat  = req.addr == `SCS_OFS_CLOCK_STATUS;

  // Clock tree wires
  logic main_clk;
  logic main_cur_sel;
  logic cpu_clk;
  logic cpu_cur_sel;
  logic ram_clk;
  logic ref_clk_1k;
  logic main_d;
  logic main_rise;
  logic periph_clk;

  // Crystal watchdog wires
  logic       xtal_d;
  logic       xtal_edge;
  logic [8:0] xtal_idle;
  logic       watch_on;
  logic       xtal_fail;
  logic       failover;

  // Crystal is watched only while it is enabled and feeding the main clock
  assign xtal_edge = fast_crystal_osc_i != xtal_d;
  assign watch_on  = cfg.crystal_en && main_cur_sel;
  assign xtal_fail = watch_on && (xtal_idle == FAIL_CYC - 9'h001);

  // Idle counter restarts on every crystal transition
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      xtal_d    <= 1'b0;
      xtal_idle <= 9'h000;
      failover  <= 1'b0;
    end else begin
      xtal_d    <= fast_crystal_osc_i;
      xtal_idle <= (xtal_edge || !watch_on || xtal_fail) ? 9'h000 : xtal_idle + 9'h001;
      // Failover holds until the main mux has left the crystal
      if (xtal_fail) begin
        failover <= 1'b1;
      end else if (!main_cur_sel) begin
        failover <= 1'b0;
      end
    end
  end

  // Main clock: RC when 0, crystal when 1; the crystal must also be powered
  scs_glitch_mux u_main_mux (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .clk_a_i   (fast_rc_osc_i),
    .clk_b_i   (fast_crystal_osc_i),
    .sel_i     (cfg.main_sel && cfg.crystal_en && !failover),
    .force_i   (failover),
    .clk_o     (main_clk),
    .cur_sel_o (main_cur_sel)
  );

  // Peripheral clock toggles on each main rising edge, so it is exactly half
  assign main_rise = main_clk && !main_d;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      main_d     <= 1'b0;
      periph_clk <= 1'b0;
    end else begin
      main_d <= main_clk;
      if (main_rise) begin
        periph_clk <= !periph_clk;
      end
    end
  end

  // CPU source: flash work pins it at 12 MHz, which is main on RC, peripheral on crystal
  wire cpu_normal_sel = cfg.cpu_sel;
  wire cpu_flash_sel  = !main_cur_sel;
  wire cpu_eff_sel    = flash_busy_i ? cpu_flash_sel : cpu_normal_sel;

  scs_glitch_mux u_cpu_mux (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .clk_a_i   (periph_clk),
    .clk_b_i   (main_clk),
    .sel_i     (cpu_eff_sel),
    .force_i   (1'b0),
    .clk_o     (cpu_clk),
    .cur_sel_o (cpu_cur_sel)
  );

  // RAM takes the inverted CPU select bit, not the flash override, so it runs at twice the peripheral rate while cpu_sel is 0
  scs_glitch_mux u_ram_mux (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .clk_a_i   (periph_clk),
    .clk_b_i   (main_clk),
    .sel_i     (!cfg.cpu_sel),
    .force_i   (1'b0),
    .clk_o     (ram_clk),
    .cur_sel_o ()
  );

  // Reference clock divider, integer and fraction straight from software
  scs_frac_div u_ref_div (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .src_i      (slow_rc_osc_10k_i),
    .div_int_i  (cfg.ref_div[`SCS_REF_INT_MSB:`SCS_REF_INT_LSB]),
    .div_frac_i (cfg.ref_div[`SCS_REF_FRAC_MSB:0]),
    .clk_o      (ref_clk_1k)
  );

  // Interrupt events
  logic flash_d;
  logic main_sel_d;
  wire  flash_start = flash_busy_i && !flash_d;
  wire  switch_done = main_cur_sel != main_sel_d;
  wire  [2:0] irq_set = {switch_done, flash_start, xtal_fail};
  wire  [2:0] irq_clr = (req.rd && hit_irq_stat) ? irq_status : 3'h0;
  wire  [2:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;

  // Software-visible configuration; failover pulls the main select back to RC
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cfg.slow_tune  <= `SCS_RST_SLOW_TUNE;
      cfg.ref_div    <= `SCS_RST_REF_DIV;
      cfg.bias       <= `SCS_RST_BIAS;
      cfg.fast_tune  <= `SCS_RST_FAST_TUNE;
      cfg.crystal_en <= 1'((`SCS_RST_CRYSTAL_CTRL >> `SCS_BIT_CRYSTAL_EN));
      cfg.main_sel   <= 1'b0;
      cfg.cpu_sel    <= `SCS_RST_CPU_SEL;
      irq_mask       <= `SCS_RST_IRQ;
    end else begin
      if (req.wr && hit_slow_tune) begin
        cfg.slow_tune <= req.wdata[3:0];
      end
      if (req.wr && hit_ref_div) begin
        cfg.ref_div <= req.wdata[15:0];
      end
      if (req.wr && hit_bias) begin
        cfg.bias <= req.wdata[3:0];
      end
      if (req.wr && hit_fast_tune) begin
        cfg.fast_tune <= req.wdata[4:0];
      end
      if (req.wr && hit_xtal_ctrl) begin
        cfg.crystal_en <= req.wdata[`SCS_BIT_CRYSTAL_EN];
      end
      // Failure wins over a same-cycle write of the select
      if (xtal_fail) begin
        cfg.main_sel <= 1'b0;
      end else if (req.wr && hit_xtal_ctrl) begin
        cfg.main_sel <= req.wdata[`SCS_BIT_MAIN_SEL];
      end
      if (req.wr && hit_cpu_clock) begin
        cfg.cpu_sel <= req.wdata[`SCS_BIT_CPU_SEL];
      end
      if (req.wr && hit_irq_mask) begin
        irq_mask <= req.wdata[2:0];
      end
    end
  end

  // Read data mux; unmapped addresses read zero
  wire [31:0] rd_clk_stat = {26'h0, flash_busy_i, failover, cpu_cur_sel, main_cur_sel,
                             cfg.crystal_en, radio_clock_ok_o};
  wire [31:0] rd_mux =
      hit_slow_tune ? {28'h0, cfg.slow_tune} :
      hit_ref_div   ? {16'h0, cfg.ref_div} :
      hit_bias      ? {28'h0, cfg.bias} :
      hit_fast_tune ? {27'h0, cfg.fast_tune} :
      hit_xtal_ctrl ? {30'h0, cfg.crystal_en, cfg.main_sel} :
      hit_cpu_clock ? {31'h0, cfg.cpu_sel} :
      hit_irq_stat  ? {29'h0, irq_status} :
      hit_irq_mask  ? {29'h0, irq_mask} :
      hit_clk_stat  ? rd_clk_stat :
      32'h0000_0000;

  // Status, read data and event outputs; set wins over read-clear
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      irq_status <= `SCS_RST_IRQ;
      flash_d    <= 1'b0;
      main_sel_d <= 1'b0;
      rdata_o    <= 32'h0000_0000;
      nmi_o      <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      flash_d    <= flash_busy_i;
      main_sel_d <= main_cur_sel;
      rdata_o    <= req.rd ? rd_mux : 32'h0000_0000;
      nmi_o      <= xtal_fail;
      irq_o      <= |(next_irq_status & irq_mask);
    end
  end

  // Clock and control outputs, all registered
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      main_clock_o         <= 1'b0;
      periph_clock_o       <= 1'b0;
      processor_clock_o    <= 1'b0;
      ram_clock_o          <= 1'b0;
      ref_clock_1k_o       <= 1'b0;
      slow_crystal_clock_o <= 1'b0;
      crystal_enable_o     <= 1'b0;
      crystal_bias_o       <= `SCS_RST_BIAS;
      fast_rc_tune_o       <= `SCS_RST_FAST_TUNE;
      slow_rc_tune_o       <= `SCS_RST_SLOW_TUNE;
      main_is_crystal_o    <= 1'b0;
      radio_clock_ok_o     <= 1'b0;
    end else begin
      main_clock_o         <= main_clk;
      periph_clock_o       <= periph_clk;
      processor_clock_o    <= cpu_clk;
      ram_clock_o          <= ram_clk;
      ref_clock_1k_o       <= ref_clk_1k;
      slow_crystal_clock_o <= slow_crystal_osc_i;
      crystal_enable_o     <= cfg.crystal_en;
      crystal_bias_o       <= cfg.bias;
      fast_rc_tune_o       <= cfg.fast_tune;
      slow_rc_tune_o       <= cfg.slow_tune;
      main_is_crystal_o    <= main_cur_sel;
      // Radio timing is only trusted on the crystal
      radio_clock_ok_o     <= main_cur_sel && cfg.crystal_en && !failover;
    end
  end

endmodule

`default_nettype wire

/* inc/scs_cfg.svh */
// Offsets, field positions, reset values and timing counts of the system clock switch
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH

// Register byte offsets
`define SCS_OFS_SLOW_TUNE     16'h000C
`define SCS_OFS_REF_DIV       16'h0010
`define SCS_OFS_BIAS          16'h4004
`define SCS_OFS_FAST_TUNE     16'h4008
`define SCS_OFS_CRYSTAL_CTRL  16'h401C
`define SCS_OFS_CPU_CLOCK     16'h4020
`define SCS_OFS_IRQ_STATUS    16'h4024
`define SCS_OFS_IRQ_MASK      16'h4028
`define SCS_OFS_CLOCK_STATUS  16'h402C

// Reset values
`define SCS_RST_SLOW_TUNE     4'h0
`define SCS_RST_REF_DIV       16'h5000
`define SCS_RST_BIAS          4'hF
`define SCS_RST_FAST_TUNE     5'h17
`define SCS_RST_CRYSTAL_CTRL  2'h0
`define SCS_RST_CPU_SEL       1'h0
`define SCS_RST_IRQ           3'h0

// Field positions
`define SCS_BIT_MAIN_SEL      0
`define SCS_BIT_CRYSTAL_EN    1
`define SCS_BIT_CPU_SEL       0
`define SCS_IRQ_CRYSTAL_FAIL  0
`define SCS_IRQ_FLASH_FORCE   1
`define SCS_IRQ_SWITCH_DONE   2
`define SCS_REF_INT_MSB       15
`define SCS_REF_INT_LSB       11
`define SCS_REF_FRAC_MSB      10

// Timing: crystal declared dead after this long without an edge
`define SCS_CLK_MHZ           250
`define SCS_XTAL_FAIL_NS      1000
`define SCS_XTAL_FAIL_CYC     ((`SCS_XTAL_FAIL_NS * `SCS_CLK_MHZ) / 1000)

`endif

/* inc/scs_pkg.sv */
// Types shared by the system clock switch
package scs_pkg;

  // One register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } scs_bus_req_t;

  // Software configuration that steers the clock tree
  typedef struct packed {
    logic [3:0]  slow_tune;
    logic [15:0] ref_div;
    logic [3:0]  bias;
    logic [4:0]  fast_tune;
    logic        crystal_en;
    logic        main_sel;
    logic        cpu_sel;
  } scs_cfg_t;

endpackage

/* hw/scs_glitch_mux.sv */
// Glitch-free two-way selector for sampled clock waveforms
`timescale 1ns/1ps
`default_nettype none

module scs_glitch_mux (
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic clk_a_i,
  input  wire logic clk_b_i,
  input  wire logic sel_i,
  input  wire logic force_i,
  output logic      clk_o,
  output logic      cur_sel_o
);

  logic cur_src;
  logic new_src;
  logic swap_ok;
  logic next_sel;

  // Unforced, hand over only while both sides are low, so no pulse is shortened
  assign cur_src  = cur_sel_o ? clk_b_i : clk_a_i;
  assign new_src  = sel_i ? clk_b_i : clk_a_i;
  assign swap_ok  = (sel_i != cur_sel_o) && !new_src && (!cur_src || force_i);
  assign next_sel = swap_ok ? sel_i : cur_sel_o;

  // A dead source may sit high forever; force lets the switch leave it
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cur_sel_o <= 1'b0;
      clk_o     <= 1'b0;
    end else begin
      cur_sel_o <= next_sel;
      clk_o     <= next_sel ? clk_b_i : clk_a_i;
    end
  end

endmodule

`default_nettype wire

/* hw/scs_frac_div.sv */
// Fractional-N divider making the 1 kHz reference from the 10 kHz oscillator
`timescale 1ns/1ps
`default_nettype none

module scs_frac_div (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        src_i,
  input  wire logic [4:0]  div_int_i,
  input  wire logic [10:0] div_frac_i,
  output logic             clk_o
);

  logic        src_d;
  logic        src_rise;
  logic [4:0]  cnt;
  logic [10:0] frac_acc;
  logic [11:0] frac_sum;
  logic [4:0]  int_eff;
  logic [5:0]  period;
  logic        wrap;
  logic [4:0]  next_cnt;

  // Ratios below two cannot form a square wave
  assign src_rise = src_i && !src_d;
  assign int_eff  = (div_int_i < 5'h02) ? 5'h02 : div_int_i;
  assign frac_sum = {1'b0, frac_acc} + {1'b0, div_frac_i};
  assign period   = {1'b0, int_eff} + {5'h00, frac_sum[11]};
  assign wrap     = ({1'b0, cnt} + 6'h01) >= period;
  assign next_cnt = wrap ? 5'h00 : cnt + 5'h01;

  // Count source edges; the fraction stretches a period by one edge
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      src_d    <= 1'b0;
      cnt      <= 5'h00;
      frac_acc <= 11'h000;
      clk_o    <= 1'b0;
    end else begin
      src_d <= src_i;
      if (src_rise) begin
        cnt   <= next_cnt;
        clk_o <= next_cnt < {1'b0, int_eff[4:1]};
        if (wrap) begin
          frac_acc <= frac_sum[10:0];
        end
      end
    end
  end

endmodule

`default_nettype wire

/* verification/scs_clock_switch_props.sv */
// Port-level property checker for the system clock switch
`timescale 1ns/1ps
`default_nettype none

module scs_clock_switch_props (
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic        slow_crystal_osc_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        slow_crystal_clock_o,
  input wire logic        crystal_enable_o,
  input wire logic [3:0]  crystal_bias_o,
  input wire logic [4:0]  fast_rc_tune_o,
  input wire logic [3:0]  slow_rc_tune_o,
  input wire logic        main_is_crystal_o,
  input wire logic        radio_clock_ok_o,
  input wire logic        nmi_o
);
  // One clock domain, so clock and reset are shared by every property
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // Trims and source right after reset
  property p_trim_reset;
    $rose(resetn_i) |-> fast_rc_tune_o == 5'h17 && crystal_bias_o == 4'hF && !main_is_crystal_o;
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("reset trims or source wrong");

  // Register then output stage: a write shows on the trim and crystal enable outputs two edges later
  property p_bias_wr;
    wr_i && addr_i == 16'h4004 |-> ##2 crystal_bias_o == $past(wdata_i[3:0], 2);
  endproperty
  a_bias_wr: assert property (p_bias_wr) else $error("bias trim not updated");
  property p_fast_tune_wr;
    wr_i && addr_i == 16'h4008 |-> ##2 fast_rc_tune_o == $past(wdata_i[4:0], 2);
  endproperty
  a_fast_tune_wr: assert property (p_fast_tune_wr) else $error("fast RC trim not updated");
  property p_slow_tune_wr;
    wr_i && addr_i == 16'h000C |-> ##2 slow_rc_tune_o == $past(wdata_i[3:0], 2);
  endproperty
  a_slow_tune_wr: assert property (p_slow_tune_wr) else $error("slow RC trim not updated");
  property p_enable_wr;
    wr_i && addr_i == 16'h401C |-> ##2 crystal_enable_o == $past(wdata_i[1], 2);
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("crystal enable not updated");

  // Only bit 0 of the CPU clock register may read non-zero
  property p_cpu_rd;
    rd_i && addr_i == 16'h4020 |=> rdata_o[31:1] == 31'h0;
  endproperty
  a_cpu_rd: assert property (p_cpu_rd) else $error("cpu clock register reserved bits set");

  // NMI is a single pulse and the main mux leaves the crystal soon after
  property p_nmi_revert;
    $rose(nmi_o) |=> !nmi_o ##[0:40] !main_is_crystal_o;
  endproperty
  a_nmi_revert: assert property (p_nmi_revert) else $error("failover did not revert to RC");

  // Radio may only be declared ready on a live, enabled crystal
  property p_radio_ok;
    $rose(radio_clock_ok_o) |-> main_is_crystal_o && crystal_enable_o;
  endproperty
  a_radio_ok: assert property (p_radio_ok) else $error("radio ready without crystal");

  // Powering the crystal down must move the main clock off it
  property p_off_reverts;
    $fell(crystal_enable_o) |-> ##[0:60] !main_is_crystal_o;
  endproperty
  a_off_reverts: assert property (p_off_reverts) else $error("main clock stayed on disabled crystal");

  // Slow crystal is a one-cycle registered pass-through
  property p_slow_pass;
    $past(resetn_i) |-> slow_crystal_clock_o == $past(slow_crystal_osc_i);
  endproperty
  a_slow_pass: assert property (p_slow_pass) else $error("slow crystal clock not passed");
endmodule

bind scs_clock_switch scs_clock_switch_props i_scs_clock_switch_props (.*);

`default_nettype wire

/* verification/scs_clock_switch_tb.sv */
// Self-checking bench for the system clock switch
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("Error %s expected %0h seen %0h", nm, e, g); end end

module scs_clock_switch_tb;
  logic        ref_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        fast_rc_osc_i = 1'b0;
  logic        fast_crystal_osc_i = 1'b0;
  logic        slow_rc_osc_10k_i = 1'b0;
  logic        slow_crystal_osc_i = 1'b0;
  logic        flash_busy_i = 1'b0;
  logic [15:0] addr_i = 16'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic        main_clock_o, periph_clock_o, processor_clock_o, ram_clock_o, ref_clock_1k_o;
  logic        slow_crystal_clock_o, crystal_enable_o, main_is_crystal_o, radio_clock_ok_o, nmi_o, irq_o;
  logic [3:0]  crystal_bias_o, slow_rc_tune_o;
  logic [4:0]  fast_rc_tune_o;
  logic [5:0]  taps, prev = 6'h0;
  logic        xtal_run = 1'b1, cnt_clr = 1'b0;
  int          ph = 0, fails = 0, n_checks = 0;
  int          cnt [6];

  scs_clock_switch i_scs_clock_switch (.*);

  always #2 ref_clk_i = ~ref_clk_i;

  // Oscillators: RC 20 cycles, crystal 10, slow RC 20; all windows are multiples so counts are exact
  assign taps = {main_clock_o, periph_clock_o, processor_clock_o, ram_clock_o, ref_clock_1k_o, slow_rc_osc_10k_i};
  always @(posedge ref_clk_i) begin
    ph <= ph + 1;
    fast_rc_osc_i <= (ph % 20) < 10;
    fast_crystal_osc_i <= xtal_run && (ph % 10) < 5;
    slow_rc_osc_10k_i <= ((ph + 3) % 20) < 10;
    slow_crystal_osc_i <= (ph % 6) < 3;
    prev <= taps;
    for (int i = 0; i < 6; i++) cnt[i] <= cnt_clr ? 0 : cnt[i] + int'(taps[i] && !prev[i]);
  end

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    rd(a, d);
    `CHK(nm, e, d)
  endtask

  // Count rising edges over exactly 400 reference cycles
  task automatic measure;
    @(posedge ref_clk_i);
    cnt_clr <= 1'b1;
    @(posedge ref_clk_i);
    cnt_clr <= 1'b0;
    repeat (400) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wrap_up;
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic t_reset;
    rd_chk(16'h000C, 32'h0, "slow_tune");
    rd_chk(16'h0010, 32'h5000, "ref_div");
    rd_chk(16'h4004, 32'hF, "bias");
    rd_chk(16'h4008, 32'h17, "fast_tune");
    rd_chk(16'h401C, 32'h0, "crystal_ctrl");
    rd_chk(16'h4020, 32'h0, "cpu_clock");
    rd_chk(16'h4028, 32'h0, "irq_mask");
    rd_chk(16'h4000, 32'h0, "unmapped");
    measure;
    `CHK("main_rate", 20, cnt[5])
  endtask

  task automatic t_regs;
    wr(16'h4004, 32'hFFFF_FFFF);
    rd_chk(16'h4004, 32'hF, "bias_rw");
    wr(16'h4008, 32'h0000_0003);
    rd_chk(16'h4008, 32'h3, "fast_tune_rw");
    `CHK("fast_tune_out", 5'h03, fast_rc_tune_o)
    wr(16'h000C, 32'h0000_0005);
    // Trim output is registered once more behind the register
    @(posedge ref_clk_i);
    #1;
    `CHK("slow_tune_out", 4'h5, slow_rc_tune_o)
  endtask

  // Every select combination, with and without flash activity
  task automatic t_modes;
    logic s1, s2, fl;
    int em;
    for (int m = 0; m < 8; m++) begin
      {fl, s2, s1} = m[2:0];
      em = s1 ? 40 : 20;
      wr(16'h401C, {30'h0, 1'b1, s1});
      wr(16'h4020, {31'h0, s2});
      flash_busy_i <= fl;
      repeat (100) @(posedge ref_clk_i);
      measure;
      `CHK("main", em, cnt[5])
      `CHK("periph", em / 2, cnt[4])
      `CHK("cpu", fl ? 20 : (s2 ? em : em / 2), cnt[3])
      `CHK("ram", s2 ? em / 2 : em, cnt[2])
      `CHK("radio_ok", s1, radio_clock_ok_o)
    end
    flash_busy_i <= 1'b0;
    // Select without enable must stay on the RC oscillator
    wr(16'h401C, 32'h1);
    repeat (100) @(posedge ref_clk_i);
    measure;
    `CHK("sel_no_en", 20, cnt[5])
    `CHK("xtal_en", 1'b0, crystal_enable_o)
  endtask

  task automatic t_fail;
    logic [31:0] d;
    int seen;
    seen = 0;
    wr(16'h401C, 32'h3);
    wr(16'h4028, 32'h7);
    repeat (100) @(posedge ref_clk_i);
    rd(16'h4024, d);
    xtal_run <= 1'b0;
    for (int i = 0; i < 400 && seen == 0; i++) begin
      @(posedge ref_clk_i);
      #1 seen = int'(nmi_o === 1'b1);
    end
    `CHK("nmi_seen", 1, seen)
    if (seen == 0) begin
      wrap_up;
    end
    repeat (100) @(posedge ref_clk_i);
    `CHK("on_crystal", 1'b0, main_is_crystal_o)
    `CHK("irq_set", 1'b1, irq_o)
    rd(16'h4024, d);
    `CHK("fail_status", 1'b1, d[0])
    `CHK("irq_clear", 1'b0, irq_o)
    rd_chk(16'h401C, 32'h2, "sel_cleared");
    rd_chk(16'h402C, 32'h0000_000A, "clk_status");
    measure;
    `CHK("main_rc", 20, cnt[5])
    // Masked event sets status but keeps the line low
    wr(16'h4028, 32'h0);
    flash_busy_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    `CHK("irq_masked", 1'b0, irq_o)
    rd(16'h4024, d);
    `CHK("flash_status", 1'b1, d[1])
    flash_busy_i <= 1'b0;
    xtal_run <= 1'b1;
  endtask

  // Reference divider: default ten, then four
  task automatic t_ref;
    measure;
    `CHK("slow_src", 20, cnt[0])
    `CHK("ref_div10", 2, cnt[1])
    wr(16'h0010, 32'h0000_2000);
    repeat (200) @(posedge ref_clk_i);
    measure;
    `CHK("ref_div4", 5, cnt[1])
  endtask

  initial begin
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_reset;
    t_regs;
    t_modes;
    t_fail;
    t_ref;
    wrap_up;
  end
endmodule

`default_nettype wire
